//--- include/rtcc_pkg.sv
// Notes on behaviour
// - One shared staging byte, software readable/writable
// - Halted debug without run bit freezes block
// - Run bit set keeps counting while halted
// - Sign zero: correction slows the prescaler
// - Sign one: prescaler faster, needs divide-by-two
// - Seven-bit amount: clocks per million ticks
// - Two-bit field selects one of four sources
// - Counter bytes at base and base+1, resets zero
// - Counter write lands two counter ticks later
// - Wrap limit bytes at base and base+1
// - Wrap limit resets to all ones
// - Limit write lands two counter ticks later
// - Correction register software written, resets zero
// - Counter at limit wraps, sets wrap flag
// - Counter equal match value sets match flag
// - Counter pending flag high during transfer
package rtcc_pkg;

  // ********************************************************
  // Bus layout
  // ********************************************************
  localparam int unsigned ADDR_W = 6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices, byte address is four times the index
  localparam logic [3:0] IDX_CTRL     = 4'h0;
  localparam logic [3:0] IDX_SYNC     = 4'h1;
  localparam logic [3:0] IDX_MASK     = 4'h2;
  localparam logic [3:0] IDX_FLAGS    = 4'h3;
  localparam logic [3:0] IDX_STAGING  = 4'h4;
  localparam logic [3:0] IDX_DEBUG    = 4'h5;
  localparam logic [3:0] IDX_CORR     = 4'h6;
  localparam logic [3:0] IDX_CLOCK_SOURCE_SELECT   = 4'h7;
  localparam logic [3:0] IDX_CNT_LO   = 4'h8;
  localparam logic [3:0] IDX_CNT_HI   = 4'h9;
  localparam logic [3:0] IDX_LIM_LO   = 4'hA;
  localparam logic [3:0] IDX_LIM_HI   = 4'hB;
  localparam logic [3:0] IDX_MATCH_LO = 4'hC;
  localparam logic [3:0] IDX_MATCH_HI = 4'hD;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_CORR_BIT  = 2;
  localparam int unsigned CTRL_PRESC_LSB = 3;
  localparam int unsigned PRESC_W        = 4;
  localparam int unsigned SYNC_CNT_BIT   = 1;
  localparam int unsigned SYNC_LIM_BIT   = 2;
  localparam int unsigned FLAG_WRAP_BIT  = 0;
  localparam int unsigned FLAG_MATCH_BIT = 1;
  localparam int unsigned CORR_SIGN_BIT  = 7;
  localparam int unsigned CORR_ERR_W     = 7;
  localparam int unsigned RUN_HALT_BIT   = 0;
  localparam int unsigned CLOCK_SOURCE_SELECT_W       = 2;
  localparam int unsigned NUM_SRC        = 4;

  // ********************************************************
  // Reset values and counts
  // ********************************************************
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_CNT   = 16'h0000;
  localparam logic [15:0] RST_LIM   = 16'hFFFF;
  localparam logic [15:0] RST_MATCH = 16'h0000;
  localparam logic [1:0]  SYNC_LAST = 2'h1;      // Two counter ticks: count 0 then 1
  localparam logic [19:0] PPM_INTERVAL = 20'hF4240; // One million counter ticks

  // Counter clock sources
  typedef enum logic [1:0] {
    SRC_INTERNAL_FAST,
    SRC_INTERNAL_SLOW,
    SRC_CRYSTAL,
    SRC_EXTERNAL
  } rtcc_src_type;

endpackage : rtcc_pkg

//--- src/rtcc_top.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rtcc_top #(
  parameter logic [19:0] PPM_INTERVAL = rtcc_pkg::PPM_INTERVAL
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write channels
  input  wire logic [rtcc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // AXI4-Lite read channels
  input  wire logic [rtcc_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Counter clock sources
  input  wire logic                       internal_fast_osc,
  input  wire logic                       internal_slow_osc,
  input  wire logic                       crystal_source,
  input  wire logic                       external_clock_pin,
  // System
  input  wire logic                       cpu_halted,
  output logic                            irq
);

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [7:0]  ctrl_r, mask_r, flags_r, staging_r, debug_r, corr_r;
  logic [1:0]  clock_source_select_r;
  logic [15:0] cnt_r, lim_r, match_r, cnt_stage_r, lim_stage_r;
  logic        cnt_pend_r, lim_pend_r;
  logic [1:0]  cnt_sync_r, lim_sync_r;
  localparam int unsigned NUM_SRC_L = rtcc_pkg::NUM_SRC;
  logic [NUM_SRC_L-1:0] src_s1_r, src_s2_r, src_s3_r, level_r;
  logic        sel_prev_r, sel_level, raw_tick, freeze, tick_en;
  logic [15:0] presc_r;
  logic [16:0] presc_sum, div;
  logic [1:0]  step;
  logic        presc_tick, corr_apply, advance;
  logic [19:0] ppm_r;
  logic [6:0]  corr_pend_r;
  logic        cnt_load, lim_load, wrap_evt, match_evt;
  logic [15:0] cnt_inc;
  logic        aw_have_r, w_have_r, aw_have_nxt, w_have_nxt;
  logic [3:0]  aw_idx_r;
  logic        aw_bad_r, wstrb0_r;
  logic [7:0]  wbyte_r;
  logic        wr_do, ar_fire, rvalid_nxt;
  logic [3:0]  ar_idx;
  logic [7:0]  rd_byte;
  logic        rd_ok;

  // Divide ratio of a prescaler setting
  function automatic logic [16:0] div_of(input logic [3:0] p);
    div_of = 17'h00001 << p;
  endfunction : div_of

  // Write strobe for one register index
  function automatic logic wr_hit(input logic go, input logic [3:0] idx,
                                  input logic [3:0] want);
    wr_hit = go && (idx == want);
  endfunction : wr_hit

  // ********************************************************
  // Counter clock input synchronisers
  // ********************************************************
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_s1_r <= '0;
      src_s2_r <= '0;
      src_s3_r <= '0;
      level_r  <= '0;
    end else begin
      src_s1_r <= {external_clock_pin, crystal_source, internal_slow_osc,
                   internal_fast_osc};
      src_s2_r <= src_s1_r;
      src_s3_r <= src_s2_r;
      level_r  <= (~(src_s2_r ^ src_s3_r) & src_s3_r) | ((src_s2_r ^ src_s3_r) & level_r);
    end
  end

  assign sel_level = level_r[clock_source_select_r];
  assign raw_tick  = sel_level & ~sel_prev_r;
  assign freeze    = cpu_halted & ~debug_r[rtcc_pkg::RUN_HALT_BIT];
  assign tick_en   = raw_tick & ~freeze;

  // Edge detector on the selected source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_prev_r <= 1'b0;
    end else begin
      sel_prev_r <= sel_level;
    end
  end

  // ********************************************************
  // Prescaler with frequency correction
  // ********************************************************
  assign corr_apply = ctrl_r[rtcc_pkg::CTRL_CORR_BIT] && (corr_pend_r != 7'h00);
  always_comb begin
    step = 2'h1;
    if (corr_apply && !corr_r[rtcc_pkg::CORR_SIGN_BIT]) begin
      step = 2'h0;
    end else if (corr_apply) begin
      step = 2'h2;
    end
  end
  assign div        = div_of(ctrl_r[rtcc_pkg::CTRL_PRESC_LSB +: rtcc_pkg::PRESC_W]);
  assign presc_sum  = {1'b0, presc_r} + {15'h0000, step};
  assign presc_tick = tick_en && (presc_sum >= div);
  assign advance    = presc_tick && ctrl_r[rtcc_pkg::CTRL_EN_BIT];

  // Prescaler count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= 16'h0000;
    end else if (tick_en) begin
      presc_r <= presc_tick ? 16'(presc_sum - div) : presc_sum[15:0];
    end
  end

  // Per-million interval and remaining correction clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ppm_r       <= 20'h00000;
      corr_pend_r <= 7'h00;
    end else if (tick_en) begin
      if (ppm_r == PPM_INTERVAL - 20'h00001) begin
        ppm_r       <= 20'h00000;
        corr_pend_r <= corr_r[rtcc_pkg::CORR_ERR_W-1:0];
      end else begin
        ppm_r <= ppm_r + 20'h00001;
        if (corr_apply) begin
          corr_pend_r <= corr_pend_r - 7'h01;
        end
      end
    end
  end

  // ********************************************************
  // Transfer of written values into the counter clock
  // ********************************************************
  assign cnt_load = cnt_pend_r && tick_en && (cnt_sync_r == rtcc_pkg::SYNC_LAST);
  assign lim_load = lim_pend_r && tick_en && (lim_sync_r == rtcc_pkg::SYNC_LAST);

  // Counter value transfer; a new write restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_pend_r  <= 1'b0;
      cnt_sync_r  <= 2'h0;
      cnt_stage_r <= rtcc_pkg::RST_CNT;
    end else if (wr_hit(wr_do, aw_idx_r, rtcc_pkg::IDX_CNT_HI)) begin
      cnt_pend_r  <= 1'b1;
      cnt_sync_r  <= 2'h0;
      cnt_stage_r <= {wbyte_r, staging_r};
    end else if (cnt_load) begin
      cnt_pend_r <= 1'b0;
    end else if (cnt_pend_r && tick_en) begin
      cnt_sync_r <= cnt_sync_r + 2'h1;
    end
  end

  // Limit value transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lim_pend_r  <= 1'b0;
      lim_sync_r  <= 2'h0;
      lim_stage_r <= rtcc_pkg::RST_LIM;
    end else if (wr_hit(wr_do, aw_idx_r, rtcc_pkg::IDX_LIM_HI)) begin
      lim_pend_r  <= 1'b1;
      lim_sync_r  <= 2'h0;
      lim_stage_r <= {wbyte_r, staging_r};
    end else if (lim_load) begin
      lim_pend_r <= 1'b0;
    end else if (lim_pend_r && tick_en) begin
      lim_sync_r <= lim_sync_r + 2'h1;
    end
  end

  // Active wrap limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lim_r <= rtcc_pkg::RST_LIM;
    end else if (lim_load) begin
      lim_r <= lim_stage_r;
    end
  end

  // ********************************************************
  // Counter, wrap and match
  // ********************************************************
  assign wrap_evt  = advance && !cnt_load && (cnt_r == lim_r);
  assign cnt_inc   = wrap_evt ? 16'h0000 : cnt_r + 16'h0001;
  assign match_evt = advance && !cnt_load && (cnt_inc == match_r);

  // Counter update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= rtcc_pkg::RST_CNT;
    end else if (cnt_load) begin
      cnt_r <= cnt_stage_r;
    end else if (advance) begin
      cnt_r <= cnt_inc;
    end
  end

  // Sticky event flags; a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= rtcc_pkg::RST_BYTE;
    end else begin
      flags_r <= (flags_r & ~(wr_hit(wr_do, aw_idx_r, rtcc_pkg::IDX_FLAGS) ? wbyte_r : 8'h00))
               | (8'(wrap_evt)  << rtcc_pkg::FLAG_WRAP_BIT)
               | (8'(match_evt) << rtcc_pkg::FLAG_MATCH_BIT);
    end
  end

  // Interrupt output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_r & mask_r);
    end
  end

  // ********************************************************
  // AXI4-Lite write path
  // ********************************************************
  assign aw_have_nxt = (aw_have_r | (awvalid & awready)) & ~wr_do;
  assign w_have_nxt  = (w_have_r | (wvalid & wready)) & ~wr_do;
  assign wr_do       = aw_have_r & w_have_r & ~bvalid;

  // Address and data holding, response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_idx_r  <= 4'h0;
      aw_bad_r  <= 1'b0;
      wbyte_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= rtcc_pkg::RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready   <= ~aw_have_nxt;
      wready    <= ~w_have_nxt;
      if (awvalid && awready) begin
        aw_idx_r <= awaddr[rtcc_pkg::ADDR_W-1:2];
        aw_bad_r <= awaddr[rtcc_pkg::ADDR_W-1:2] > rtcc_pkg::IDX_MATCH_HI;
      end
      if (wvalid && wready) begin
        wbyte_r  <= wdata[7:0];
        wstrb0_r <= wstrb[0];
      end
      if (wr_do) begin
        bvalid <= 1'b1;
        bresp  <= aw_bad_r ? rtcc_pkg::RESP_SLVERR : rtcc_pkg::RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Plain register writes; low lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= rtcc_pkg::RST_BYTE;
      mask_r   <= rtcc_pkg::RST_BYTE;
      debug_r  <= rtcc_pkg::RST_BYTE;
      corr_r   <= rtcc_pkg::RST_BYTE;
      clock_source_select_r <= 2'h0;
      match_r  <= rtcc_pkg::RST_MATCH;
    end else if (wr_do && wstrb0_r) begin
      case (aw_idx_r)
        rtcc_pkg::IDX_CTRL:     ctrl_r   <= wbyte_r & 8'h7D;
        rtcc_pkg::IDX_MASK:     mask_r   <= wbyte_r & 8'h03;
        rtcc_pkg::IDX_DEBUG:    debug_r  <= wbyte_r & 8'h01;
        rtcc_pkg::IDX_CORR:     corr_r   <= wbyte_r;
        rtcc_pkg::IDX_CLOCK_SOURCE_SELECT:   clock_source_select_r <= wbyte_r[rtcc_pkg::CLOCK_SOURCE_SELECT_W-1:0];
        rtcc_pkg::IDX_MATCH_HI: match_r  <= {wbyte_r, staging_r};
        default: ;
      endcase
    end
  end

  // ********************************************************
  // AXI4-Lite read path
  // ********************************************************
  assign ar_fire    = arvalid & arready;
  assign rvalid_nxt = ar_fire | (rvalid & ~rready);
  assign ar_idx     = araddr[rtcc_pkg::ADDR_W-1:2];

  // Read data selection
  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    case (ar_idx)
      rtcc_pkg::IDX_CTRL:     rd_byte = ctrl_r;
      rtcc_pkg::IDX_SYNC:     rd_byte = 8'({lim_pend_r, cnt_pend_r, 1'b0});
      rtcc_pkg::IDX_MASK:     rd_byte = mask_r;
      rtcc_pkg::IDX_FLAGS:    rd_byte = flags_r;
      rtcc_pkg::IDX_STAGING:  rd_byte = staging_r;
      rtcc_pkg::IDX_DEBUG:    rd_byte = debug_r;
      rtcc_pkg::IDX_CORR:     rd_byte = corr_r;
      rtcc_pkg::IDX_CLOCK_SOURCE_SELECT:   rd_byte = 8'(clock_source_select_r);
      rtcc_pkg::IDX_CNT_LO:   rd_byte = cnt_r[7:0];
      rtcc_pkg::IDX_LIM_LO:   rd_byte = lim_r[7:0];
      rtcc_pkg::IDX_MATCH_LO: rd_byte = match_r[7:0];
      rtcc_pkg::IDX_CNT_HI,
      rtcc_pkg::IDX_LIM_HI,
      rtcc_pkg::IDX_MATCH_HI: rd_byte = staging_r;
      default:                rd_ok   = 1'b0;
    endcase
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= rtcc_pkg::RESP_OKAY;
    end else begin
      arready <= ~rvalid_nxt;
      rvalid  <= rvalid_nxt;
      if (ar_fire) begin
        rdata <= {24'h000000, rd_byte};
        rresp <= rd_ok ? rtcc_pkg::RESP_OKAY : rtcc_pkg::RESP_SLVERR;
      end
    end
  end

  // Shared staging byte: bus write first, then low-byte reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      staging_r <= rtcc_pkg::RST_BYTE;
    end else if (wr_do && wstrb0_r && (aw_idx_r == rtcc_pkg::IDX_STAGING
             || aw_idx_r == rtcc_pkg::IDX_CNT_LO || aw_idx_r == rtcc_pkg::IDX_LIM_LO
             || aw_idx_r == rtcc_pkg::IDX_MATCH_LO)) begin
      staging_r <= wbyte_r;
    end else if (ar_fire && ar_idx == rtcc_pkg::IDX_CNT_LO) begin
      staging_r <= cnt_r[15:8];
    end else if (ar_fire && ar_idx == rtcc_pkg::IDX_LIM_LO) begin
      staging_r <= lim_r[15:8];
    end else if (ar_fire && ar_idx == rtcc_pkg::IDX_MATCH_LO) begin
      staging_r <= match_r[15:8];
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  a_freeze_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    freeze && !cnt_load |=> $stable(cnt_r)) else $error("counter moved while frozen");
  a_halt_run: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_halted && advance && !cnt_load && cnt_r != lim_r |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter stalled while halted with run bit");
  a_pos_slow: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_en && corr_apply && !corr_r[7] |=> $stable(presc_r))
    else $error("positive correction did not skip");
  a_neg_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_en && corr_apply && corr_r[7] && presc_sum < div |=> presc_r == $past(presc_r) + 16'h0002)
    else $error("negative correction did not add");
  a_ppm_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_en && ppm_r == PPM_INTERVAL - 20'h00001 |=> corr_pend_r == $past(corr_r[6:0]))
    else $error("correction amount not reloaded");
  a_cnt_two_ticks: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_load |-> cnt_pend_r && cnt_sync_r == 2'h1 && tick_en)
    else $error("counter loaded early");
  a_cnt_pending: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_hit(wr_do, aw_idx_r, rtcc_pkg::IDX_CNT_HI) |=> cnt_pend_r ##1 cnt_pend_r)
    else $error("pending flag dropped too soon");
  a_lim_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> lim_r == 16'hFFFF) else $error("limit reset value wrong");
  a_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    wrap_evt |=> cnt_r == 16'h0000 && flags_r[0]) else $error("wrap failed");
  a_match_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    match_evt |=> flags_r[1]) else $error("match flag not set");
  a_lo_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && ar_idx == rtcc_pkg::IDX_CNT_LO && !wr_do |=> staging_r == $past(cnt_r[15:8]))
    else $error("high byte not latched");
  c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) wrap_evt);
  c_cnt_load: cover property (@(posedge aclk) disable iff (!aresetn) cnt_load);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_corr: cover property (@(posedge aclk) disable iff (!aresetn) tick_en && corr_apply);

endmodule : rtcc_top
`default_nettype wire

//--- dv/rtcc_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_osc_model (
  // Counter clock sources
  output var logic fast_o,
  output var logic slow_o,
  output var logic xtal_o,
  output var logic ext_o
);
  // Free-running sources, each level spans several bus clocks
  initial begin
    fast_o = 1'h0;
    slow_o = 1'h0;
    xtal_o = 1'h0;
    ext_o  = 1'h0;
  end
  // Crystal and pin sources come up already enabled and running
  always #20 fast_o = ~fast_o;
  always #70 slow_o = ~slow_o;
  always #30 xtal_o = ~xtal_o;
  always #45 ext_o = ~ext_o;
endmodule : rtcc_osc_model
`default_nettype wire

//--- dv/rtc_counter_clock_calibration_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_counter_clock_calibration_regs_bench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_halted;
  logic        awready, wready, bvalid, arready, rvalid, irq, fast, slow, xtal, ext;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] a, b, val;
  int          err_total, compares, cyc, mdl [16];
  localparam int PPM = 20;                          // Short correction interval
  int          src_period_ns [4] = '{40, 140, 60, 90}; // Periods of the source model

  // Bus clock and hang guard
  initial aclk = 1'h0;
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end

  rtcc_top #(.PPM_INTERVAL(20'(PPM))) u_rtcc_top (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .internal_fast_osc(fast), .internal_slow_osc(slow),
    .crystal_source(xtal), .external_clock_pin(ext), .cpu_halted(cpu_halted), .irq(irq));
  rtcc_osc_model u_rtcc_osc_model (.fast_o(fast), .slow_o(slow), .xtal_o(xtal), .ext_o(ext));

  // ********************************************************
  // Bus tasks and comparison
  // ********************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Count compared against a window of tolerance
  task automatic chk_near(input string nm, input int e, input logic [15:0] g, input int tol);
    compares++;
    if ($isunknown(g) || int'(g) > e + tol || int'(g) < e - tol) begin
      err_total++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_near

  task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= {i, 2'h0};
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if ((awready & awvalid) === 1'h1) awvalid <= 1'h0;
      if ((wready & wvalid) === 1'h1) wvalid <= 1'h0;
    end while ((bvalid & bready) !== 1'h1);
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    // Model of the plain byte registers and the shared staging byte
    case (i)
      4'h4, 4'h6: mdl[i] = d;
      4'h5: mdl[i] = d & 8'h01;
      4'h7: mdl[i] = d & 8'h03;
      4'h8, 4'hA: mdl[4] = d;
      default: ;
    endcase
  endtask : wr

  task automatic rdr(input logic [3:0] i, input logic [1:0] er, output logic [31:0] g);
    @(posedge aclk);
    araddr  <= {i, 2'h0};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if ((arready & arvalid) === 1'h1) arvalid <= 1'h0;
    end while ((rvalid & rready) !== 1'h1);
    rready <= 1'h0;
    g = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rdr

  task automatic rd16(input logic [3:0] i, output logic [15:0] g);
    logic [31:0] lo, hi;
    rdr(i, 2'h0, lo);
    rdr(4'(i + 1), 2'h0, hi);
    g = {hi[7:0], lo[7:0]};
    mdl[4] = hi[7:0];
  endtask : rd16

  // Counter advance over n cycles plus the six of the two reads
  task automatic span(input int n, output logic [15:0] d);
    logic [15:0] s0, s1;
    rd16(4'h8, s0);
    repeat (n) @(posedge aclk);
    rd16(4'h8, s1);
    d = s1 - s0;
  endtask : span

  task automatic wr16(input logic [3:0] i, input logic [15:0] d);
    wr(i, d[7:0], 2'h0);
    wr(4'(i + 1), d[15:8], 2'h0);
  endtask : wr16

  task automatic wait_clear(input int bit_n);
    int n;
    n = 0;
    do begin
      rdr(4'h1, 2'h0, rd);
      n++;
    end while (rd[bit_n] !== 1'h0 && n < 60);
    chk("sync pending", 32'h0, {31'h0, rd[bit_n]});
  endtask : wait_clear

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, cpu_halted} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 48'h0;
    err_total = 0;
    compares = 0;
    mdl = '{default: 0};
    aresetn = 1'h0;
    void'($urandom(5670));
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 4; i < 8; i++) begin
      rdr(4'(i), 2'h0, rd);
      chk("reset byte", 32'(mdl[i]), rd);
    end
    rd16(4'h8, a);
    chk("counter reset", 32'h0, {16'h0, a});
    rd16(4'hA, a);
    chk("limit reset", 32'h0000FFFF, {16'h0, a});
    $display("reset test done");
    repeat (6) for (int i = 4; i < 8; i++) begin
      wr(4'(i), 8'($urandom), 2'h0);
      rdr(4'(i), 2'h0, rd);
      chk("byte register", 32'(mdl[i]), rd);
    end
    wr(4'hE, 8'h5A, 2'h2);
    rdr(4'hF, 2'h2, rd);
    $display("byte register test done");
    // Slow source so the two-tick transfer is still pending when read
    wr(4'h7, 8'h01, 2'h0);
    wr(4'h0, 8'h00, 2'h0);
    val = 16'($urandom);
    wr16(4'h8, val);
    rdr(4'h1, 2'h0, rd);
    chk("counter pending", 32'h1, {31'h0, rd[1]});
    wait_clear(1);
    rd16(4'h8, a);
    chk("counter value", {16'h0, val}, {16'h0, a});
    wr16(4'hA, 16'h0003);
    rdr(4'h1, 2'h0, rd);
    chk("limit pending", 32'h1, {31'h0, rd[2]});
    rd16(4'hA, a);
    chk("limit before transfer", 32'h0000FFFF, {16'h0, a});
    wait_clear(2);
    rd16(4'hA, a);
    chk("limit value", 32'h3, {16'h0, a});
    $display("transfer test done");
    // Wrap with the interrupt first masked, then unmasked, then cleared
    wr16(4'h8, 16'h0000);
    wait_clear(1);
    wr(4'h0, 8'h01, 2'h0);
    repeat (300) @(posedge aclk);
    rdr(4'h3, 2'h0, rd);
    chk("wrap flag", 32'h1, {31'h0, rd[0]});
    chk("match flag", 32'h1, {31'h0, rd[1]});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(4'h2, 8'h01, 2'h0);
    repeat (3) @(posedge aclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(4'h0, 8'h00, 2'h0);
    repeat (40) @(posedge aclk);
    wr(4'h3, 8'h03, 2'h0);
    rdr(4'h3, 2'h0, rd);
    chk("flags cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("wrap test done");
    // Debug halt, then every source at its own rate over 1000 ns
    wr16(4'hA, 16'hFFFF);
    wait_clear(2);
    wr(4'h0, 8'h01, 2'h0);
    wr(4'h5, 8'h00, 2'h0);
    cpu_halted <= 1'h1;
    rd16(4'h8, a);
    repeat (200) @(posedge aclk);
    rd16(4'h8, b);
    chk("frozen count", {16'h0, a}, {16'h0, b});
    wr(4'h5, 8'h01, 2'h0);
    rd16(4'h8, a);
    repeat (200) @(posedge aclk);
    rd16(4'h8, b);
    chk("runs when halted", 32'h1, {31'h0, a !== b});
    cpu_halted <= 1'h0;
    for (int s = 0; s < 4; s++) begin
      wr(4'h7, 8'(s), 2'h0);
      span(194, val);
      chk_near("source ticks", 1000 / src_period_ns[s], val, 2);
    end
    $display("halt and source test done");
    // Correction of 5 per interval; window of 100 fast ticks, slower then faster
    wr(4'h7, 8'h00, 2'h0);
    wr(4'h6, 8'h05, 2'h0);
    wr(4'h0, 8'h05, 2'h0);
    repeat (200) @(posedge aclk);
    span(794, val);
    chk_near("slowed count", 100 * (PPM - 5) / PPM, val, 3);
    wr(4'h0, 8'h15, 2'h0);
    wr(4'h6, 8'h85, 2'h0);
    repeat (200) @(posedge aclk);
    span(794, val);
    chk_near("hastened count", 100 * (PPM + 5) / (PPM * 4), val, 3);
    wr(4'h0, 8'h00, 2'h0);
    $display("correction test done");
    wrap_up();
  end
endmodule : rtc_counter_clock_calibration_regs_bench
`default_nettype wire
